// ---- design/fpc_pkg.sv ----
// package of constants and types for the flash program control block
package fpc_pkg;

  // ********************************
  // register map, byte addresses
  // ********************************
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] TARGET_OFS     = 8'h04;
  localparam logic [7:0] KEY_OFS        = 8'h08;
  localparam logic [7:0] MAIN_SIZE_OFS  = 8'h0c;
  localparam logic [7:0] BOOT_SIZE_OFS  = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h18;

  // ********************************
  // control register fields
  // ********************************
  localparam int GO_BIT      = 15;
  localparam int UNLOCK_BIT  = 14;
  localparam int FAIL_BIT    = 13;
  localparam int LOW_ERR_BIT = 12;
  localparam int LOW_ACT_BIT = 11;

  // ********************************
  // operation codes
  // ********************************
  localparam logic [3:0] OP_CLEAR     = 4'h0;
  localparam logic [3:0] OP_WORD      = 4'h1;
  localparam logic [3:0] OP_ROW       = 4'h3;
  localparam logic [3:0] OP_PAGE      = 4'h4;
  localparam logic [3:0] OP_ERASE_ALL = 4'h5;

  // ********************************
  // sizes and keys
  // ********************************
  localparam logic [31:0] MAIN_SIZE_RESET = 32'h0002_0000;
  localparam logic [31:0] BOOT_SIZE_VAL   = 32'h0000_0c00;
  // key values are arbitrary
  localparam logic [31:0] KEY_FIRST       = 32'h5a5a_1234;
  localparam logic [31:0] KEY_SECOND      = 32'ha5a5_4321;
  localparam logic [1:0]  KEY_ARMED       = 2'h2;

  // interrupt status bits: done, fail, low supply error
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_LOW_BIT  = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RUN} fpc_state_type;

endpackage

// ---- design/fpc_flash_program_control.sv ----
// flash program control: register slave, unlock detector and operation sequencer
`timescale 1ns/100ps
module fpc_flash_program_control #(
  parameter logic [31:0] MAIN_FLASH_BYTES = fpc_pkg::MAIN_SIZE_RESET
) (
  input  wire logic        sys_clk,
  input  wire logic        por_rst,
  input  wire logic        rst,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        flash_done,
  input  wire logic        flash_fail,
  input  wire logic        flash_target_protected,
  input  wire logic        flash_any_protected,
  input  wire logic        low_supply_pin,
  output logic             flash_start,
  output logic      [3:0]  flash_op,
  output logic      [31:0] flash_addr,
  output logic             low_supply_detector_en,
  output logic             irq
);
  import fpc_pkg::*;

  // only the five sizes that the size register can report are accepted
  if (MAIN_FLASH_BYTES != 32'h0000_4000 && MAIN_FLASH_BYTES != 32'h0000_8000 &&
      MAIN_FLASH_BYTES != 32'h0001_0000 && MAIN_FLASH_BYTES != 32'h0002_0000 &&
      MAIN_FLASH_BYTES != 32'h0004_0000) begin : g_bad_size
    $error("main flash size not supported");
  end

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    fpc_state_type st;
    logic          go;
    logic          unlock_en;
    logic          fail;
    logic          low_err;
    logic          low_act;
    logic [3:0]    op;
    logic [31:0]   addr_sw;
    logic [31:0]   addr_hold;
    logic [1:0]    key_stage;
    logic          start;
    logic [3:0]    op_out;
    logic [2:0]    stat;
    logic [2:0]    mask;
    logic          irq;
    logic [31:0]   rdata;
    logic          ls_meta;
    logic          ls_sync;
  } fpc_regs_type;

  localparam fpc_regs_type REGS_RESET = '{
    st: ST_IDLE, go: 1'b0, unlock_en: 1'b0, fail: 1'b0, low_err: 1'b0,
    low_act: 1'b0, op: 4'h0, addr_sw: 32'h0, addr_hold: 32'h0,
    key_stage: 2'h0, start: 1'b0, op_out: 4'h0, stat: 3'h0, mask: 3'h0,
    irq: 1'b0, rdata: 32'h0, ls_meta: 1'b0, ls_sync: 1'b0};

  fpc_regs_type state_reg;
  fpc_regs_type state_next;

  function automatic logic [31:0] ctrl_word(input fpc_regs_type s);
    logic [31:0] w;
    w              = 32'h0;
    w[GO_BIT]      = s.go;
    w[UNLOCK_BIT]  = s.unlock_en;
    w[FAIL_BIT]    = s.fail;
    w[LOW_ERR_BIT] = s.low_err;
    w[LOW_ACT_BIT] = s.low_act;
    w[3:0]         = s.op;
    return w;
  endfunction

  function automatic logic is_targeted(input logic [3:0] op);
    return (op == OP_WORD) || (op == OP_ROW) || (op == OP_PAGE);
  endfunction

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic       wr_ctrl;
    logic       go_req;
    logic       finish;
    logic [2:0] events;
    wr_ctrl    = bus_wr && (bus_addr == CTRL_OFS);
    go_req     = 1'b0;
    finish     = 1'b0;
    events     = 3'h0;
    state_next = state_reg;
    state_next.start = 1'b0;
    state_next.rdata = 32'h0;

    // low supply pin is asynchronous
    state_next.ls_meta = low_supply_pin;
    state_next.ls_sync = state_reg.ls_meta;

    // unlock detector: any access other than the right key breaks the sequence
    // the arm lasts one access, so a stray read between key and go needs a new pair
    if (bus_wr || bus_rd) begin
      state_next.key_stage = 2'h0;
      if (bus_wr && bus_addr == KEY_OFS) begin
        if (state_reg.key_stage == 2'h0 && bus_wdata == KEY_FIRST) begin
          state_next.key_stage = 2'h1;
        end else if (state_reg.key_stage == 2'h1 && bus_wdata == KEY_SECOND) begin
          state_next.key_stage = KEY_ARMED;
        end
      end
    end

    // ********************************
    // register writes
    // ********************************
    if (wr_ctrl) begin
      if (!state_reg.unlock_en) begin
        state_next.op = bus_wdata[3:0];
      end
      state_next.unlock_en = bus_wdata[UNLOCK_BIT];
      go_req = bus_wdata[GO_BIT] && state_reg.unlock_en && !state_reg.go &&
               state_reg.key_stage == KEY_ARMED;
    end
    if (bus_wr && bus_addr == TARGET_OFS) begin
      state_next.addr_sw = bus_wdata;
    end
    if (bus_wr && bus_addr == IRQ_MASK_OFS) begin
      state_next.mask = bus_wdata[2:0];
    end
    if (go_req) begin
      state_next.go        = 1'b1;
      state_next.addr_hold = state_reg.addr_sw;
      state_next.st        = ST_CHECK;
    end

    // ********************************
    // sequencer
    // ********************************
    unique case (state_reg.st)
      ST_IDLE: begin
      end
      ST_CHECK: begin
        // protection is a level from the array side, looked at once, here
        if (is_targeted(state_reg.op)) begin
          if (flash_target_protected) begin
            finish = 1'b1;
          end else begin
            state_next.start  = 1'b1;
            state_next.op_out = state_reg.op;
            state_next.st     = ST_RUN;
          end
        end else if (state_reg.op == OP_ERASE_ALL) begin
          if (flash_any_protected) begin
            finish = 1'b1;
          end else begin
            state_next.start  = 1'b1;
            state_next.op_out = state_reg.op;
            state_next.st     = ST_RUN;
          end
        end else begin
          if (state_reg.op == OP_CLEAR) begin
            state_next.fail    = 1'b0;
            state_next.low_err = 1'b0;
          end
          finish = 1'b1;
        end
      end
      ST_RUN: begin
        if (flash_done) begin
          state_next.fail = flash_fail;
          events[IRQ_FAIL_BIT] = flash_fail;
          finish = 1'b1;
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
    if (finish) begin
      state_next.go = 1'b0;
      state_next.st = ST_IDLE;
      events[IRQ_DONE_BIT] = 1'b1;
    end

    // detector runs off the current enable; error flag cleared by code zero, live flag is not
    state_next.low_act = state_reg.unlock_en && state_reg.ls_sync;
    if (state_reg.unlock_en && state_reg.ls_sync) begin
      state_next.low_err = 1'b1;
      events[IRQ_LOW_BIT] = !state_reg.low_err;
    end

    // ********************************
    // reads, interrupt status
    // ********************************
    if (bus_rd) begin
      unique case (bus_addr)
        CTRL_OFS:      state_next.rdata = ctrl_word(state_reg);
        TARGET_OFS:    state_next.rdata = state_reg.addr_sw;
        MAIN_SIZE_OFS: state_next.rdata = MAIN_FLASH_BYTES;
        BOOT_SIZE_OFS: state_next.rdata = BOOT_SIZE_VAL;
        IRQ_STAT_OFS:  state_next.rdata = {29'h0, state_reg.stat};
        IRQ_MASK_OFS:  state_next.rdata = {29'h0, state_reg.mask};
        default:       state_next.rdata = 32'h0;
      endcase
    end
    // set wins over the read clear
    if (bus_rd && bus_addr == IRQ_STAT_OFS) begin
      state_next.stat = events;
    end else begin
      state_next.stat = state_reg.stat | events;
    end
    state_next.irq = |(state_next.stat & state_next.mask);

    // device reset touches only the unlock path
    if (rst) begin
      state_next.unlock_en = 1'b0;
      state_next.key_stage = 2'h0;
      // a start already decided stands; run would otherwise wait for a done that never comes
    end
  end

  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      state_reg <= REGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata              = state_reg.rdata;
  assign flash_start            = state_reg.start;
  assign flash_op               = state_reg.op_out;
  assign flash_addr             = state_reg.addr_hold;
  assign low_supply_detector_en = state_reg.unlock_en;
  assign irq                    = state_reg.irq;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking

  go_needs_unlock_a: assert property (disable iff (por_rst)
    $rose(state_reg.go) |-> $past(state_reg.unlock_en) && $past(state_reg.key_stage) == KEY_ARMED)
    else $error("go set without unlock");
  go_clears_a: assert property (disable iff (por_rst || rst)
    state_reg.st == ST_RUN && flash_done |=> !state_reg.go && state_reg.st == ST_IDLE)
    else $error("go not cleared at completion");
  reset_keeps_a: assert property (disable iff (por_rst)
    rst |=> !state_reg.unlock_en && state_reg.op == $past(state_reg.op))
    else $error("device reset changed wrong fields");
  detector_off_a: assert property (disable iff (por_rst)
    !state_reg.unlock_en |=> !state_reg.low_act)
    else $error("low supply active while detector off");
  fail_flag_a: assert property (disable iff (por_rst || rst)
    state_reg.st == ST_RUN && flash_done |=> state_reg.fail == $past(flash_fail))
    else $error("fail flag does not follow result");
  low_error_a: assert property (disable iff (por_rst || rst)
    state_reg.unlock_en && state_reg.ls_sync |=> state_reg.low_err)
    else $error("low supply error not set");
  op_locked_a: assert property (disable iff (por_rst)
    state_reg.unlock_en |=> state_reg.op == $past(state_reg.op))
    else $error("operation changed while unlocked");
  protect_skip_a: assert property (disable iff (por_rst || rst)
    state_reg.st == ST_CHECK && flash_target_protected && is_targeted(state_reg.op)
    |=> !state_reg.start && !state_reg.go)
    else $error("protected target was started");
  clear_flags_a: assert property (disable iff (por_rst || rst)
    state_reg.st == ST_CHECK && state_reg.op == OP_CLEAR |=> !state_reg.fail)
    else $error("clear code left fail flag");
  size_read_a: assert property (disable iff (por_rst)
    bus_rd && bus_addr == MAIN_SIZE_OFS |=> bus_rdata == MAIN_FLASH_BYTES)
    else $error("main size read wrong");
  key_disarm_a: assert property (disable iff (por_rst)
    (bus_rd || (bus_wr && bus_addr != KEY_OFS)) |=> state_reg.key_stage == 2'h0)
    else $error("unlock survived a foreign access");
  addr_latch_a: assert property (disable iff (por_rst)
    $rose(state_reg.go) |-> state_reg.addr_hold == $past(state_reg.addr_sw))
    else $error("target address not latched");

  // ********************************
  // checks on the flash side and the flags
  // ********************************
  start_pulse_a: assert property (disable iff (por_rst)
    state_reg.start |=> !state_reg.start)
    else $error("start longer than one cycle");

  start_code_a: assert property (disable iff (por_rst)
    state_reg.start |-> is_targeted(state_reg.op_out) || state_reg.op_out == OP_ERASE_ALL)
    else $error("start with a code that does nothing");

  op_out_hold_a: assert property (disable iff (por_rst)
    !state_reg.start |-> $stable(state_reg.op_out))
    else $error("operation code moved without a start");

  erase_guard_a: assert property (disable iff (por_rst || rst)
    state_reg.st == ST_CHECK && state_reg.op == OP_ERASE_ALL && flash_any_protected
    |=> !state_reg.start && !state_reg.go)
    else $error("erase all started with a protected page");

  go_locked_a: assert property (disable iff (por_rst)
    !state_reg.go && !state_reg.unlock_en |=> !state_reg.go)
    else $error("go set while writes were blocked");

  unlock_write_a: assert property (disable iff (por_rst || rst)
    bus_wr && bus_addr == CTRL_OFS |=> state_reg.unlock_en == $past(bus_wdata[UNLOCK_BIT]))
    else $error("unlock enable did not take the written value");

  go_no_key_a: assert property (disable iff (por_rst)
    bus_wr && bus_addr == CTRL_OFS && !state_reg.go && state_reg.key_stage != KEY_ARMED
    |=> !state_reg.go)
    else $error("go set without the key pair");

  key_arm_a: assert property (disable iff (por_rst || rst)
    bus_wr && bus_addr == KEY_OFS && bus_wdata == KEY_SECOND && state_reg.key_stage == 2'h1
    |=> state_reg.key_stage == KEY_ARMED)
    else $error("key pair did not arm go");

  op_write_a: assert property (disable iff (por_rst)
    !state_reg.unlock_en && bus_wr && bus_addr == CTRL_OFS
    |=> state_reg.op == $past(bus_wdata[3:0]))
    else $error("operation select write lost while locked");

  fail_hold_a: assert property (disable iff (por_rst)
    !(state_reg.st == ST_RUN && flash_done) &&
    !(state_reg.st == ST_CHECK && state_reg.op == OP_CLEAR) |=> $stable(state_reg.fail))
    else $error("fail flag moved without a result or a clear");

  low_err_hold_a: assert property (disable iff (por_rst)
    state_reg.low_err && !(state_reg.st == ST_CHECK && state_reg.op == OP_CLEAR)
    |=> state_reg.low_err)
    else $error("low supply error dropped without a clear");

  low_active_a: assert property (disable iff (por_rst)
    state_reg.unlock_en && state_reg.ls_sync |=> state_reg.low_act)
    else $error("low supply active missed a live event");

  low_inactive_a: assert property (disable iff (por_rst)
    !state_reg.ls_sync |=> !state_reg.low_act)
    else $error("low supply active without a live event");

  clear_low_a: assert property (disable iff (por_rst)
    state_reg.st == ST_CHECK && state_reg.op == OP_CLEAR &&
    !(state_reg.unlock_en && state_reg.ls_sync) |=> !state_reg.low_err)
    else $error("clear code left low supply error");

  boot_read_a: assert property (disable iff (por_rst)
    bus_rd && bus_addr == BOOT_SIZE_OFS |=> bus_rdata == BOOT_SIZE_VAL)
    else $error("boot size read wrong");

  addr_stable_a: assert property (disable iff (por_rst)
    state_reg.go && $past(state_reg.go) |-> $stable(state_reg.addr_hold))
    else $error("target address moved during an operation");

endmodule

// ---- tb/fpc_flash_model.sv ----
// behavioural model of the flash array answering start pulses
`timescale 1ns/100ps
module fpc_flash_model #(
  parameter int LAT = 4
) (
  input  wire logic sys_clk,
  input  wire logic flash_start,
  input  wire logic fail_req,
  output logic      flash_done,
  output logic      flash_fail
);
  int cnt_reg;
  initial begin
    cnt_reg = 0;
    flash_done = 1'b0;
    flash_fail = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (flash_start) cnt_reg <= LAT;
    else if (cnt_reg > 0) cnt_reg <= cnt_reg - 1;
    flash_done <= (cnt_reg == 1);
    // outside the done pulse the fail line toggles, so nothing leans on a stale value
    flash_fail <= (cnt_reg == 1) ? fail_req : ~flash_fail;
  end
endmodule

// ---- tb/tb_fpc_flash_program_control.sv ----
// testbench for the flash program control block
`timescale 1ns/100ps
module tb_fpc_flash_program_control;
  import fpc_pkg::*;
  logic sys_clk, por_rst, rst, bus_wr, bus_rd, tprot, aprot, low_pin, fail_req;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata, faddr, v;
  logic [3:0]  fop;
  logic        fstart, fdone, ffail, det_en, irq;
  int errors = 0, check_count = 0, starts = 0;
  fpc_flash_program_control i_dut (.sys_clk(sys_clk), .por_rst(por_rst), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .flash_done(fdone), .flash_fail(ffail),
    .flash_target_protected(tprot), .flash_any_protected(aprot), .low_supply_pin(low_pin),
    .flash_start(fstart), .flash_op(fop), .flash_addr(faddr),
    .low_supply_detector_en(det_en), .irq(irq));
  fpc_flash_model i_model (.sys_clk(sys_clk), .flash_start(fstart), .fail_req(fail_req),
    .flash_done(fdone), .flash_fail(ffail));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (fstart === 1'b1) starts <= starts + 1;
  // ********************************
  // bus tasks
  // ********************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_rd <= 1'b1; bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    d = bus_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // op set while locked, then unlock, key, key, go; wait for go to drop
  task automatic run(input logic [3:0] op, input logic f, input int n, input logic [31:0] ec);
    int s0;
    fail_req <= f;
    s0 = starts;
    wr(CTRL_OFS, {28'h0, op});
    wr(CTRL_OFS, {16'h0, 4'h4, 8'h0, op});
    wr(KEY_OFS, KEY_FIRST);
    wr(KEY_OFS, KEY_SECOND);
    wr(CTRL_OFS, {16'h0, 4'hc, 8'h0, op});
    v = 32'h8000;
    for (int i = 0; i < 20 && v[15] !== 1'b0; i++) rd(CTRL_OFS, v);
    chk(32'(starts - s0), 32'(n));
    chk(v, ec);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  // ********************************
  // tests
  // ********************************
  initial begin
    por_rst = 1'b1; rst = 1'b1; bus_wr = 1'b0; bus_rd = 1'b0; bus_addr = 8'h00;
    bus_wdata = 32'h0; tprot = 1'b0; aprot = 1'b0; low_pin = 1'b0; fail_req = 1'b0;
    repeat (3) @(posedge sys_clk);
    por_rst <= 1'b0; rst <= 1'b0;
    rdc(MAIN_SIZE_OFS, 32'h0002_0000);
    rdc(BOOT_SIZE_OFS, 32'h0000_0c00);
    wr(BOOT_SIZE_OFS, 32'hffff_ffff);
    rdc(BOOT_SIZE_OFS, 32'h0000_0c00);
    rdc(CTRL_OFS, 32'h0);
    rdc(8'hfc, 32'h0);
    wr(IRQ_MASK_OFS, 32'h7);
    rdc(IRQ_MASK_OFS, 32'h7);
    wr(TARGET_OFS, 32'h0000_1230);
    wr(CTRL_OFS, 32'h1);
    wr(CTRL_OFS, 32'h4001);
    chk(det_en, 32'h1);
    wr(CTRL_OFS, 32'hc003);
    rdc(CTRL_OFS, 32'h4001);
    run(OP_WORD, 1'b0, 1, 32'h4001);
    chk(fop, OP_WORD);
    chk(faddr, 32'h0000_1230);
    chk(irq, 32'h1);
    rdc(IRQ_STAT_OFS, 32'h1);
    rdc(IRQ_STAT_OFS, 32'h0);
    chk(irq, 32'h0);
    wr(TARGET_OFS, 32'h0000_0800);
    run(OP_ROW, 1'b1, 1, 32'h6003);
    chk(faddr, 32'h0000_0800);
    run(OP_CLEAR, 1'b0, 0, 32'h4000);
    tprot <= 1'b1;
    run(OP_PAGE, 1'b0, 0, 32'h4004);
    tprot <= 1'b0; aprot <= 1'b1;
    run(OP_ERASE_ALL, 1'b0, 0, 32'h4005);
    aprot <= 1'b0;
    run(OP_ERASE_ALL, 1'b0, 1, 32'h4005);
    run(4'h6, 1'b0, 0, 32'h4006);
    run(4'hf, 1'b0, 0, 32'h400f);
    wr(CTRL_OFS, 32'h0);
    rd(IRQ_STAT_OFS, v);
    chk(det_en, 32'h0);
    low_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(CTRL_OFS, v);
    chk(v & 32'h1000, 32'h0);
    wr(CTRL_OFS, 32'h400f);
    repeat (6) @(posedge sys_clk);
    rdc(CTRL_OFS, 32'h580f);
    low_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rdc(CTRL_OFS, 32'h500f);
    rdc(IRQ_STAT_OFS, 32'h4);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rdc(CTRL_OFS, 32'h100f);
    run(OP_CLEAR, 1'b0, 0, 32'h4000);
    end_of_test();
  end
endmodule
